// >>> logic/dadc_regs.vh
/*
 * Constants for the dual converter control and serial readout block.
 * Assumes a 125 MHz ref_clk; times are in ns, counts derived from them.
 */
`ifndef DADC_REGS_VH
`define DADC_REGS_VH

`define DADC_CLK_MHZ 125
`define DADC_SYNC_LAT 3
`define DADC_T_CONV14_NS 680
`define DADC_T_CONV12_NS 610
`define DADC_T_BUSY_RISE_NS 40
`define DADC_CONV_ADJ 2
// Longest times round down; sync latency is taken out of the budget
`define DADC_CONV14_CYC ((`DADC_T_CONV14_NS * `DADC_CLK_MHZ) / 1000 - `DADC_SYNC_LAT)
`define DADC_CONV12_CYC ((`DADC_T_CONV12_NS * `DADC_CLK_MHZ) / 1000 - `DADC_SYNC_LAT)
`define DADC_CNT_W 7
`define DADC_RES_W 14
`define DADC_FRAME_W 28
`define DADC_BITCNT_W 5
`define DADC_FIFO_DEPTH 4

`endif

// >>> logic/dadc_fifo.v
/*
 * Small FIFO with valid/ready on both sides and a registered read stage.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module dadc_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire ref_clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop_mem;

  // ---------------------------------------------
  // Storage and pointers
  // ---------------------------------------------
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  // Refill the output stage whenever it empties or is taken
  assign pop_mem = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop_mem) begin
        rd_q <= rd_q + 1'b1;
        out_data <= mem[rd_q];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
    end
  end
endmodule

// >>> logic/dadc_top.v
/*
 * Conversion control and serial readout of a dual simultaneous converter.
 * Assumes the analog core presents both results on ref_clk; pins arrive
 * asynchronously and the read clock is sampled, not used as a clock.
 */
`timescale 1ns/1ns
`include "dadc_regs.vh"
module dadc_top #(
  parameter VARIANT14 = 1
) (
  input wire ref_clk,
  input wire srst,
  input wire convert_start_n,
  input wire cs_n,
  input wire sclk,
  input wire chan_sel,
  input wire [`DADC_RES_W-1:0] core_result_a,
  input wire [`DADC_RES_W-1:0] core_result_b,
  output reg busy_q,
  output reg mux_sel_q,
  output reg result_out_a_q,
  output reg result_out_a_oe_q,
  output reg result_out_b_q,
  output reg result_out_b_oe_q
);
  // Two cycles of the budget go to the count-zero cycle in ST_CONV and the push state
  localparam integer CONV_FULL = (VARIANT14 ? `DADC_CONV14_CYC : `DADC_CONV12_CYC) - `DADC_CONV_ADJ;
  localparam [`DADC_CNT_W-1:0] CONV_LOAD = CONV_FULL[`DADC_CNT_W-1:0];
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_PUSH = 2'h2;

  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  reg [1:0] cnv_s_q;
  reg [1:0] cs_s_q;
  reg [1:0] sclk_s_q;
  reg [1:0] sel_s_q;
  reg cnv_d1_q;
  reg cs_d1_q;
  reg sclk_d1_q;

  // Seeds match idle pin levels, so release gives no false edge
  always @(posedge ref_clk) begin
    if (srst) begin
      cnv_s_q <= 2'h3;
      cs_s_q <= 2'h3;
      sclk_s_q <= 2'h3;
      sel_s_q <= 2'h0;
      cnv_d1_q <= 1'b1;
      cs_d1_q <= 1'b1;
      sclk_d1_q <= 1'b1;
    end else begin
      cnv_s_q <= {cnv_s_q[0], convert_start_n};
      cs_s_q <= {cs_s_q[0], cs_n};
      sclk_s_q <= {sclk_s_q[0], sclk};
      sel_s_q <= {sel_s_q[0], chan_sel};
      cnv_d1_q <= cnv_s_q[1];
      cs_d1_q <= cs_s_q[1];
      sclk_d1_q <= sclk_s_q[1];
    end
  end

  wire cnv_fall;
  wire sclk_fall;
  wire cs_low;
  wire cs_rise;
  assign cnv_fall = cnv_d1_q & ~cnv_s_q[1];
  assign sclk_fall = sclk_d1_q & ~sclk_s_q[1];
  assign cs_low = ~cs_s_q[1];
  assign cs_rise = ~cs_d1_q & cs_s_q[1];

  // ---------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [`DADC_CNT_W-1:0] cnt_q;
  wire fifo_in_ready;
  wire fifo_push = (st_q == ST_PUSH);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (cnv_fall) begin
          st_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (cnt_q == {`DADC_CNT_W{1'b0}}) begin
          st_d = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // A full buffer holds busy high rather than drop a result
        if (fifo_in_ready) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cnt_q <= {`DADC_CNT_W{1'b0}};
      busy_q <= 1'b0;
      mux_sel_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == ST_IDLE) begin
        cnt_q <= CONV_LOAD;
      end else if (cnt_q != {`DADC_CNT_W{1'b0}}) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (st_q == ST_IDLE && cnv_fall) begin
        busy_q <= 1'b1;
        mux_sel_q <= sel_s_q[1];
      end else if (fifo_push && fifo_in_ready) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Result buffer
  // ---------------------------------------------
  wire fifo_out_valid;
  wire [2*`DADC_RES_W-1:0] fifo_out_data;
  reg have_q;
  // Buffer output waits while the shifter holds a result
  wire fifo_take = ~have_q;

  dadc_fifo #(
    .WIDTH(2*`DADC_RES_W),
    .DEPTH(`DADC_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({core_result_a, core_result_b}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------
  // Serial readout
  // ---------------------------------------------
  wire [`DADC_RES_W-1:0] res_a = fifo_out_data[2*`DADC_RES_W-1:`DADC_RES_W];
  wire [`DADC_RES_W-1:0] res_b = fifo_out_data[`DADC_RES_W-1:0];
  // both results padded for short variant
  wire [`DADC_FRAME_W-1:0] frame_a = VARIANT14 ? {res_a, res_b} : {res_a[11:0], 2'h0, res_b[11:0], 2'h0};
  wire [`DADC_FRAME_W-1:0] frame_b = VARIANT14 ? {res_b, res_a} : {res_b[11:0], 2'h0, res_a[11:0], 2'h0};

  reg [`DADC_FRAME_W-1:0] sh_a_q;
  reg [`DADC_FRAME_W-1:0] sh_b_q;
  reg [`DADC_BITCNT_W-1:0] bits_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      have_q <= 1'b0;
      sh_a_q <= {`DADC_FRAME_W{1'b0}};
      sh_b_q <= {`DADC_FRAME_W{1'b0}};
      bits_q <= {`DADC_BITCNT_W{1'b0}};
      result_out_a_q <= 1'b0;
      result_out_b_q <= 1'b0;
      result_out_a_oe_q <= 1'b0;
      result_out_b_oe_q <= 1'b0;
    end else begin
      // Sync path puts enable and float near 24 ns, not 10 ns
      // drive only while selected
      result_out_a_oe_q <= cs_low;
      result_out_b_oe_q <= cs_low;
      if (~have_q && fifo_out_valid) begin
        have_q <= 1'b1;
        sh_a_q <= frame_a;
        sh_b_q <= frame_b;
        bits_q <= {`DADC_BITCNT_W{1'b0}};
      end else if (have_q && cs_low && sclk_fall) begin
        sh_a_q <= {sh_a_q[`DADC_FRAME_W-2:0], 1'b0};
        sh_b_q <= {sh_b_q[`DADC_FRAME_W-2:0], 1'b0};
        // Saturate so a very long read still consumes the result
        if (bits_q != {`DADC_BITCNT_W{1'b1}}) begin
          bits_q <= bits_q + 1'b1;
        end
      end else if (have_q && cs_rise && bits_q != {`DADC_BITCNT_W{1'b0}}) begin
        // A read that clocked bits consumes the result
        have_q <= 1'b0;
      end
      result_out_a_q <= have_q & sh_a_q[`DADC_FRAME_W-1];
      result_out_b_q <= have_q & sh_b_q[`DADC_FRAME_W-1];
    end
  end
endmodule

// >>> test/dadc_properties.sv
/* Pin assertions for dadc_top; assumes sclk idles high outside frames. */
`timescale 1ns/1ns
module dadc_properties (
  input wire ref_clk,
  input wire srst,
  input wire convert_start_n,
  input wire cs_n,
  input wire sclk,
  input wire busy_q,
  input wire mux_sel_q,
  input wire result_out_a_q,
  input wire result_out_a_oe_q,
  input wire result_out_b_oe_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence bit_edge;
    !cs_n && $fell(sclk);
  endsequence
  chk_busy_rise: assert property ($fell(convert_start_n) && !busy_q |-> ##[3:4] busy_q)
    else $error("busy late");
  chk_busy_cause: assert property ($rose(busy_q) |-> !$past(convert_start_n, 3))
    else $error("busy unasked");
  chk_busy_min: assert property ($rose(busy_q) |=> busy_q [*8])
    else $error("busy short");
  chk_mux_latch: assert property ($changed(mux_sel_q) |-> $rose(busy_q))
    else $error("select moved");
  chk_oe_on: assert property ($fell(cs_n) |-> ##3 result_out_a_oe_q)
    else $error("not driven");
  chk_oe_off: assert property ($rose(cs_n) |-> ##3 !result_out_a_oe_q)
    else $error("not floated");
  chk_oe_pair: assert property (result_out_a_oe_q == result_out_b_oe_q)
    else $error("enables differ");
  chk_bit_hold: assert property (bit_edge |=> $stable(result_out_a_q) [*3])
    else $error("bit moved");
endmodule
bind dadc_top dadc_properties u_dadc_properties (
  .ref_clk(ref_clk),
  .srst(srst),
  .convert_start_n(convert_start_n),
  .cs_n(cs_n),
  .sclk(sclk),
  .busy_q(busy_q),
  .mux_sel_q(mux_sel_q),
  .result_out_a_q(result_out_a_q),
  .result_out_a_oe_q(result_out_a_oe_q),
  .result_out_b_oe_q(result_out_b_oe_q)
);

// >>> test/dadc_host.sv
/* Host model: start pulses and framed reads; sclk idles high, 80 ns period. */
`timescale 1ns/1ns
module dadc_host (
  input wire ref_clk,
  input wire result_out_a_q,
  input wire result_out_a_oe_q,
  input wire result_out_b_q,
  input wire result_out_b_oe_q,
  output reg convert_start_n = 1'b1,
  output reg cs_n = 1'b1,
  output reg sclk = 1'b1,
  output reg chan_sel = 1'b0
);
  // Floating pins read as z so a stray sample never matches
  wire pin_a = result_out_a_oe_q ? result_out_a_q : 1'bz;
  wire pin_b = result_out_b_oe_q ? result_out_b_q : 1'bz;
  // wake wait of 70 us before the first start
  task wake;
    repeat (8750) @(posedge ref_clk);
  endtask
  // select set a cycle early, held
  task start(input logic ch);
    @(posedge ref_clk) chan_sel <= ch;
    @(posedge ref_clk) convert_start_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    convert_start_n <= 1'b1;
  endtask
  task read(input int n, output logic [27:0] a, output logic [27:0] b);
    a = 28'h0;
    b = 28'h0;
    @(posedge ref_clk) cs_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    repeat (n) begin
      a = {a[26:0], pin_a};
      b = {b[26:0], pin_b};
      sclk <= 1'b0;
      repeat (5) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (5) @(posedge ref_clk);
    end
    cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// >>> test/tb.sv
/* Bench for dadc_top, 14-bit variant; assumes the host model dadc_host. */
`timescale 1ns/1ns
`include "dadc_regs.vh"
module tb;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [`DADC_RES_W-1:0] core_result_a = 14'h0000;
  reg [`DADC_RES_W-1:0] core_result_b = 14'h0000;
  reg [15:0] lfsr = 16'h0037;
  reg [27:0] exp_q[$];
  int fails = 0;
  int samples_checked = 0;
  int done_cnt;
  logic freed;
  wire convert_start_n, cs_n, sclk, chan_sel, busy_q, mux_sel_q;
  wire result_out_a_q, result_out_a_oe_q, result_out_b_q, result_out_b_oe_q;
  dadc_top u_dadc_top (
    .ref_clk(ref_clk),
    .srst(srst),
    .convert_start_n(convert_start_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .chan_sel(chan_sel),
    .core_result_a(core_result_a),
    .core_result_b(core_result_b),
    .busy_q(busy_q),
    .mux_sel_q(mux_sel_q),
    .result_out_a_q(result_out_a_q),
    .result_out_a_oe_q(result_out_a_oe_q),
    .result_out_b_q(result_out_b_q),
    .result_out_b_oe_q(result_out_b_oe_q)
  );
  dadc_host u_dadc_host (
    .ref_clk(ref_clk),
    .result_out_a_q(result_out_a_q),
    .result_out_a_oe_q(result_out_a_oe_q),
    .result_out_b_q(result_out_b_q),
    .result_out_b_oe_q(result_out_b_oe_q),
    .convert_start_n(convert_start_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .chan_sel(chan_sel)
  );
  initial forever #4 ref_clk = ~ref_clk;
  // About three times the expected run
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    report_and_stop;
  end
  function automatic [15:0] lfsr_next(input [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Pin b carries the pair swapped
  function automatic [27:0] pin_frame(input [27:0] e, input int n, input bit swap);
    pin_frame = (swap ? {e[13:0], e[27:14]} : e) >> (28 - n);
  endfunction
  task check(input [27:0] seen, input [27:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task conv;
    int k;
    logic [13:0] ra;
    @(posedge ref_clk);
    lfsr = lfsr_next(lfsr);
    ra = lfsr[13:0];
    lfsr = lfsr_next(lfsr);
    core_result_a <= ra;
    core_result_b <= lfsr[13:0];
    exp_q.push_back({ra, lfsr[13:0]});
    u_dadc_host.start(lfsr[15]);
    check(28'(mux_sel_q), 28'(lfsr[15]));
    // wait for busy to fall; k counts edges since the start fall
    for (k = 7; k < 120 && busy_q; k++) @(negedge ref_clk);
    freed = !busy_q;
    if (freed) check(28'(k * 8 <= `DADC_T_CONV14_NS), 28'h1);
  endtask
  task rd(input int n);
    logic [27:0] a, b, e;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 28'h0;
    u_dadc_host.read(n, a, b);
    check(a, pin_frame(e, n, 1'b0));
    check(b, pin_frame(e, n, 1'b1));
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    u_dadc_host.wake;
    repeat (3) begin
      conv;
      rd(28);
    end
    $display("test convert_read done");
    done_cnt = 0;
    freed = 1'b1;
    while (freed && done_cnt < 7) begin
      conv;
      done_cnt += freed;
    end
    // Full buffer must hold busy high
    check(28'(done_cnt >= 4 && !freed), 28'h1);
    $display("test fill done");
    rd(5);
    while (exp_q.size() > 0) rd(28);
    rd(28);
    $display("test drain done");
    report_and_stop;
  end
endmodule
